// ---- verilog/ttc_core.sv ----
// 8-bit timer/counter with two compare units behind an APB slave.
// Assumes port data/direction and interrupt acks come from pclk logic;
// the external count pin is asynchronous and is synchronised here.
// Functional notes
// - Select zero stops ticks and count
// - Tick clears, increments or decrements by mode
// - Count readable and writable at any time
// - Count write beats hardware count update
// - Mode field split across control A/B
// - Match sets compare flag on next tick
// - Enabled flag requests interrupt, cleared on service
// - Writing one clears flag, zero keeps
// - PWM modes double buffer compare values
// - Compare access targets buffer when buffering
// - Force strobe acts as match, non-PWM
// - Count write blocks matches next tick
// - Output states kept across mode change
// - Action bits unbuffered, take effect promptly
// - Reset clears both output states
// - Nonzero action overrides port pin data
// - Action zero leaves output state alone
// - Actions select polarity or set/clear/toggle
// - Normal mode counts up, wraps FF->00
// - Normal mode overflow flag on wrap
// - Zero is bottom, FF is max
// - Each interrupt gated by own mask bit
//
// Design decisions made here: the APB register port and the register offsets.
module ttc_core
  import ttc_pkg::*;
(
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  input wire logic ext_count_pin, // External count pin
  input wire logic [1:0] port_data, // Port data, b/a
  input wire logic [1:0] port_dir, // Pin direction bits, b/a
  input wire logic [2:0] irq_ack, // Interrupt serviced
  output logic [2:0] irq_req, // Interrupt requests
  output ttc_pkg::ttc_pin_type pins // Compare pins
);
  import ttc_pkg::*;

  // ==========================================================
  // State
  typedef struct packed {
    logic [7:0] ctrl_a;
    logic [7:0] ctrl_b;
    logic [7:0] count;
    logic [7:0] cmp_a;
    logic [7:0] cmp_b;
    logic [7:0] buf_a;
    logic [7:0] buf_b;
    logic [2:0] mask;
    logic [2:0] flags;
    ttc_dir_type dir;
    logic block;
    logic oc_a;
    logic oc_b;
    logic [9:0] presc;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] irq;
    ttc_pin_type pins;
  } ttc_state_type;

  ttc_state_type st_q;
  ttc_state_type st_d;

  // ==========================================================
  // Functions
  // Register select from address; shared by read and write paths
  function automatic logic [6:0] reg_sel(input logic [7:0] a);
    reg_sel = {a == TTC_OFS_FLAGS, a == TTC_OFS_MASK,
               a == TTC_OFS_CMP_B, a == TTC_OFS_CMP_A,
               a == TTC_OFS_COUNT, a == TTC_OFS_CTRL_B,
               a == TTC_OFS_CTRL_A};
  endfunction

  // Output state on a non-PWM style event (match or force)
  function automatic logic act_match(input logic [1:0] act, input logic oc);
    unique case (act)
      TTC_ACT_TOGGLE: act_match = ~oc;
      TTC_ACT_CLEAR: act_match = 1'b0;
      TTC_ACT_SET: act_match = 1'b1;
      default: act_match = oc;
    endcase
  endfunction

  // Output state in PWM modes; up marks the cleared-on-match edge
  function automatic logic act_pwm(input logic [1:0] act, input logic oc,
                                   input logic up, input logic tog_ok);
    unique case (act)
      TTC_ACT_TOGGLE: act_pwm = tog_ok ? ~oc : oc;
      TTC_ACT_CLEAR: act_pwm = ~up; // Non-inverted
      TTC_ACT_SET: act_pwm = up; // Inverted
      default: act_pwm = oc;
    endcase
  endfunction

  // ==========================================================
  // Decoded controls
  logic [2:0] mode;
  logic [2:0] cs;
  logic [1:0] act_a;
  logic [1:0] act_b;
  logic fast;
  logic phase;
  logic pwm;
  logic [7:0] top;
  logic tick;
  logic wr;
  logic [6:0] sel;
  logic cnt_wr;
  logic match_a;
  logic match_b;

  // Mode bits: two low in control A, high in control B
  assign mode = {st_q.ctrl_b[TTC_WGM_HI_BIT],
                 st_q.ctrl_a[TTC_WGM_LO_LSB +: 2]};
  assign cs = st_q.ctrl_b[TTC_CS_LSB +: 3];
  assign act_a = st_q.ctrl_a[TTC_ACT_A_LSB +: 2];
  assign act_b = st_q.ctrl_a[TTC_ACT_B_LSB +: 2];
  assign fast = (mode == TTC_WGM_FAST_FF) || (mode == TTC_WGM_FAST_OCR);
  assign phase = (mode == TTC_WGM_PHASE_FF) || (mode == TTC_WGM_PHASE_OCR);
  assign pwm = fast | phase;
  // Top is max in fixed modes, compare A in variable ones
  assign top = (mode == TTC_WGM_PHASE_OCR || mode == TTC_WGM_FAST_OCR ||
                mode == TTC_WGM_CLR_MATCH) ? st_q.cmp_a : TTC_MAX;

  // Tick: prescaler taps or synchronised pin edges
  always_comb
  begin
    unique case (cs)
      TTC_CS_STOP: tick = 1'b0;
      TTC_CS_DIV1: tick = 1'b1;
      TTC_CS_DIV8: tick = &st_q.presc[2:0];
      TTC_CS_DIV64: tick = &st_q.presc[5:0];
      TTC_CS_DIV256: tick = &st_q.presc[7:0];
      TTC_CS_DIV1024: tick = &st_q.presc[9:0];
      TTC_CS_EXT_FALL: tick = st_q.ext_s3 & ~st_q.ext_s2;
      default: tick = st_q.ext_s2 & ~st_q.ext_s3;
    endcase
  end

  // Bus write strobe in the access phase
  assign wr = psel & penable & pwrite & st_q.pready;
  assign sel = reg_sel(paddr);
  assign cnt_wr = wr & sel[2];
  // Matches are suppressed for one tick after a count write
  assign match_a = (st_q.count == st_q.cmp_a) & ~st_q.block;
  assign match_b = (st_q.count == st_q.cmp_b) & ~st_q.block;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [2:0] fset;
    logic [2:0] fclr;
    logic bottom_evt;
    logic top_evt;
    fset = TTC_RST_FLAGS;
    fclr = TTC_RST_FLAGS;
    bottom_evt = 1'b0;
    top_evt = 1'b0;
    st_d = st_q;
    // Prescaler runs only while a source is selected
    st_d.presc = (cs == TTC_CS_STOP) ? TTC_RST_PRESC : st_q.presc + 10'h001;
    // Pin synchroniser plus one stage for edge detection
    st_d.ext_s1 = ext_count_pin;
    st_d.ext_s2 = st_q.ext_s1;
    st_d.ext_s3 = st_q.ext_s2;

    if (tick)
    begin
      st_d.block = 1'b0;
      fset[TTC_FLG_CMP_A] = match_a;
      fset[TTC_FLG_CMP_B] = match_b;
      // Counting sequence per mode
      if (phase)
      begin
        unique case (st_q.dir)
          TTC_UP:
          begin
            if (st_q.count == top)
            begin
              st_d.dir = TTC_DOWN;
              st_d.count = st_q.count - 8'h01;
              top_evt = 1'b1;
            end
            else
              st_d.count = st_q.count + 8'h01;
          end
          TTC_DOWN:
          begin
            if (st_q.count == TTC_BOTTOM)
            begin
              st_d.dir = TTC_UP;
              st_d.count = st_q.count + 8'h01;
              fset[TTC_FLG_OVF] = 1'b1; // Overflow at bottom
            end
            else
              st_d.count = st_q.count - 8'h01;
          end
        endcase
        // Buffered compares land at top
        if (top_evt)
        begin
          st_d.cmp_a = st_q.buf_a;
          st_d.cmp_b = st_q.buf_b;
        end
        if (match_a)
          st_d.oc_a = act_pwm(act_a, st_q.oc_a, st_q.dir == TTC_UP,
                              mode[2]);
        if (match_b)
          st_d.oc_b = act_pwm(act_b, st_q.oc_b, st_q.dir == TTC_UP,
                              1'b0);
      end
      else if (fast)
      begin
        st_d.dir = TTC_UP;
        bottom_evt = (st_q.count == top);
        st_d.count = bottom_evt ? TTC_BOTTOM : st_q.count + 8'h01;
        fset[TTC_FLG_OVF] = bottom_evt; // Overflow at top
        if (bottom_evt)
        begin
          st_d.cmp_a = st_q.buf_a;
          st_d.cmp_b = st_q.buf_b;
        end
        if (match_a)
          st_d.oc_a = act_pwm(act_a, st_q.oc_a, 1'b1, mode[2]);
        if (match_b)
          st_d.oc_b = act_pwm(act_b, st_q.oc_b, 1'b1, 1'b0);
        // Bottom edge applied last so a max compare holds steady
        if (bottom_evt)
        begin
          st_d.oc_a = act_pwm(act_a, st_d.oc_a, 1'b0, 1'b0);
          st_d.oc_b = act_pwm(act_b, st_d.oc_b, 1'b0, 1'b0);
        end
      end
      else
      begin
        // Normal counts up and wraps; clear-on-match clears at A
        st_d.dir = TTC_UP;
        if (mode == TTC_WGM_CLR_MATCH && match_a)
          st_d.count = TTC_BOTTOM;
        else
          st_d.count = st_q.count + 8'h01;
        // Overflow in the tick the count wraps from max; a clear at A below max sets no overflow flag
        fset[TTC_FLG_OVF] = (st_q.count == TTC_MAX);
        if (match_a)
          st_d.oc_a = act_match(act_a, st_q.oc_a);
        if (match_b)
          st_d.oc_b = act_match(act_b, st_q.oc_b);
      end
    end

    // Register writes; mode change leaves output states as they are
    if (wr)
    begin
      if (sel[0])
        st_d.ctrl_a = pwdata[7:0]; // Actions apply at once
      if (sel[1])
      begin
        st_d.ctrl_b = pwdata[7:0] & 8'h0F; // Force bits never stored
        // Force acts like a match, no flag and no clear
        if (!pwm && pwdata[TTC_FORCE_A_BIT])
          st_d.oc_a = act_match(act_a, st_d.oc_a);
        if (!pwm && pwdata[TTC_FORCE_B_BIT])
          st_d.oc_b = act_match(act_b, st_d.oc_b);
      end
      if (sel[2])
      begin
        st_d.count = pwdata[7:0]; // Written value wins
        st_d.block = 1'b1;
      end
      // Buffer only while PWM; otherwise straight to active
      if (sel[3])
      begin
        st_d.buf_a = pwdata[7:0];
        if (!pwm)
          st_d.cmp_a = pwdata[7:0];
      end
      if (sel[4])
      begin
        st_d.buf_b = pwdata[7:0];
        if (!pwm)
          st_d.cmp_b = pwdata[7:0];
      end
      if (sel[5])
        st_d.mask = pwdata[2:0];
      if (sel[6])
        fclr = pwdata[2:0]; // Write one to clear
    end

    // Flags: service and software clear, set wins
    st_d.flags = (st_q.flags & ~(fclr | irq_ack)) | fset;
    // Requests gated per source
    st_d.irq = st_q.flags & st_q.mask;

    // Pin drive: compare state overrides data if action nonzero
    st_d.pins.out_a = (act_a != TTC_ACT_NONE) ? st_q.oc_a : port_data[0];
    st_d.pins.out_b = (act_b != TTC_ACT_NONE) ? st_q.oc_b : port_data[1];
    st_d.pins.oe_n_a = ~port_dir[0];
    st_d.pins.oe_n_b = ~port_dir[1];

    // APB answer one cycle after setup; reads have no side effects
    st_d.pready = psel & ~penable;
    st_d.pslverr = psel & ~penable & ~(|sel);
    st_d.prdata = 32'h0000_0000;
    if (psel && !penable)
    begin
      unique case (1'b1)
        sel[0]: st_d.prdata[7:0] = st_q.ctrl_a;
        sel[1]: st_d.prdata[7:0] = st_q.ctrl_b;
        sel[2]: st_d.prdata[7:0] = st_q.count;
        sel[3]: st_d.prdata[7:0] = pwm ? st_q.buf_a : st_q.cmp_a;
        sel[4]: st_d.prdata[7:0] = pwm ? st_q.buf_b : st_q.cmp_b;
        sel[5]: st_d.prdata[2:0] = st_q.mask;
        sel[6]: st_d.prdata[2:0] = st_q.flags;
        default: st_d.prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // State register; output states clear on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= '0;
      st_q.dir <= TTC_UP;
      st_q.pins.oe_n_a <= 1'b1;
      st_q.pins.oe_n_b <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign irq_req = st_q.irq;
  assign pins = st_q.pins;

  // ==========================================================
  // Checks
  a_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    (cs == TTC_CS_STOP && !cnt_wr) |=> $stable(st_q.count))
    else $error("count moved while stopped");

  a_normal_inc: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && mode == TTC_WGM_NORMAL && !cnt_wr) |=>
    st_q.count == $past(st_q.count) + 8'h01)
    else $error("normal mode did not increment");

  a_write_wins: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_wr |=> st_q.count == $past(pwdata[7:0]) && st_q.block)
    else $error("count write lost");

  a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && match_a) |=> st_q.flags[TTC_FLG_CMP_A])
    else $error("compare A flag not set");

  a_block_match: assert property (@(posedge pclk) disable iff (!presetn)
    (cnt_wr ##1 (!tick && !cnt_wr) [*3] ##1 tick) |->
    !match_a && !match_b)
    else $error("match not blocked after count write");

  a_flag_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && sel[6] && pwdata[TTC_FLG_CMP_B] && !(tick && match_b)) |=>
    !st_q.flags[TTC_FLG_CMP_B])
    else $error("flag B not cleared by write one");

  a_pin_override: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 pins.out_a == ($past(act_a) != TTC_ACT_NONE ?
    $past(st_q.oc_a) : $past(port_data[0])))
    else $error("pin A source wrong");

  a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq_req == ($past(st_q.flags) & $past(st_q.mask)))
    else $error("interrupt not gated by mask");

  a_ovf_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (tick && mode == TTC_WGM_NORMAL && st_q.count == TTC_MAX && !cnt_wr)
    |=> st_q.count == TTC_BOTTOM && st_q.flags[TTC_FLG_OVF])
    else $error("overflow on wrap missing");

  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("APB ready timing wrong");
endmodule

// ---- verilog/ttc_pkg.sv ----
// Constants, field layouts and carrier types of the 8-bit timer core.
// Assumes a 100 MHz APB clock and a single asynchronous low reset.
package ttc_pkg;

  // ==========================================================
  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] TTC_OFS_CTRL_A = 8'h00;
  localparam logic [7:0] TTC_OFS_CTRL_B = 8'h04;
  localparam logic [7:0] TTC_OFS_COUNT = 8'h08;
  localparam logic [7:0] TTC_OFS_CMP_A = 8'h0C;
  localparam logic [7:0] TTC_OFS_CMP_B = 8'h10;
  localparam logic [7:0] TTC_OFS_MASK = 8'h14;
  localparam logic [7:0] TTC_OFS_FLAGS = 8'h18;

  // ==========================================================
  // Field positions
  localparam int TTC_ACT_A_LSB = 6;
  localparam int TTC_ACT_B_LSB = 4;
  localparam int TTC_WGM_LO_LSB = 0;
  localparam int TTC_FORCE_A_BIT = 7;
  localparam int TTC_FORCE_B_BIT = 6;
  localparam int TTC_WGM_HI_BIT = 3;
  localparam int TTC_CS_LSB = 0;
  localparam int TTC_FLG_OVF = 0;
  localparam int TTC_FLG_CMP_A = 1;
  localparam int TTC_FLG_CMP_B = 2;

  // ==========================================================
  // Values after reset and fixed count limits
  localparam logic [7:0] TTC_RST_BYTE = 8'h00;
  localparam logic [2:0] TTC_RST_FLAGS = 3'h0;
  localparam logic [9:0] TTC_RST_PRESC = 10'h000;
  localparam logic [7:0] TTC_BOTTOM = 8'h00;
  localparam logic [7:0] TTC_MAX = 8'hFF;

  // Clock source codes
  localparam logic [2:0] TTC_CS_STOP = 3'h0;
  localparam logic [2:0] TTC_CS_DIV1 = 3'h1;
  localparam logic [2:0] TTC_CS_DIV8 = 3'h2;
  localparam logic [2:0] TTC_CS_DIV64 = 3'h3;
  localparam logic [2:0] TTC_CS_DIV256 = 3'h4;
  localparam logic [2:0] TTC_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TTC_CS_EXT_FALL = 3'h6;

  // Waveform mode codes
  localparam logic [2:0] TTC_WGM_NORMAL = 3'h0;
  localparam logic [2:0] TTC_WGM_PHASE_FF = 3'h1;
  localparam logic [2:0] TTC_WGM_CLR_MATCH = 3'h2;
  localparam logic [2:0] TTC_WGM_FAST_FF = 3'h3;
  localparam logic [2:0] TTC_WGM_PHASE_OCR = 3'h5;
  localparam logic [2:0] TTC_WGM_FAST_OCR = 3'h7;

  // Compare output action codes
  localparam logic [1:0] TTC_ACT_NONE = 2'h0;
  localparam logic [1:0] TTC_ACT_TOGGLE = 2'h1;
  localparam logic [1:0] TTC_ACT_CLEAR = 2'h2;
  localparam logic [1:0] TTC_ACT_SET = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    TTC_UP = 2'b01,
    TTC_DOWN = 2'b10
  } ttc_dir_type;

  typedef struct packed {
    logic out_a;
    logic oe_n_a;
    logic out_b;
    logic oe_n_b;
  } ttc_pin_type;

endpackage

// ---- testbench/ttc_apb_host.sv ----
// ==========================================================
// APB master model standing in for the processor core.
// Assumes one free-running pclk; a hang is reported, not waited out.
module ttc_apb_host
(
  input wire logic pclk, // System clock
  output logic psel, // APB select
  output logic penable, // APB enable
  output logic pwrite, // APB direction
  output logic [7:0] paddr, // APB byte address
  output logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr // APB error
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // One transfer; request held until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic err,
    output logic to);
    int n;
    begin
      to = 1'b1;
      q = 32'h0;
      err = 1'b0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16 && to; n++)
      begin
        @(posedge pclk);
        if (pready === 1'b1)
        begin
          q = prdata;
          err = pslverr;
          to = 1'b0;
        end
      end
      // Released lines carry junk so stale values cannot pass
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
    end
  endtask
endmodule

// ---- testbench/eight_bit_timer_compare_core_test.sv ----
// ==========================================================
// Self-checking bench of the timer core, APB host model in front.
// Assumes the core answers APB in a bounded time and pins lag a cycle.
module eight_bit_timer_compare_core_test
  import ttc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr, c, g, d;
  logic [31:0] pwdata, prdata, q;
  logic ext_count_pin;
  logic [1:0] port_data, port_dir, pd, pr;
  logic [2:0] irq_ack, irq_req;
  ttc_pin_type pins;
  int errors, checks_done, i, k, seed;
  logic [1:0] acts [4] = '{2'h1, 2'h3, 2'h2, 2'h1};
  logic exps [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

  ttc_core u_ttc_core (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_count_pin(ext_count_pin), .port_data(port_data),
    .port_dir(port_dir), .irq_ack(irq_ack), .irq_req(irq_req),
    .pins(pins));
  ttc_apb_host u_ttc_apb_host (.pclk(pclk), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ==========================================================
  // Verdict, comparison and bus helpers
  task automatic close_out();
    begin
      if (errors == 0 && checks_done > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      checks_done++;
      if (seen !== exp)
      begin
        errors++;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // A hung transfer ends the run at once
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] dv);
    logic to;
    begin
      u_ttc_apb_host.xfer(w, a, dv, q, e, to);
      if (to)
      begin
        errors++;
        close_out();
      end
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    bus(1'b1, a, dv);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(q, exp);
    end
  endtask

  // Run with control B value b for n cycles, then stop the clock source
  task automatic run(input logic [7:0] b, input int n);
    begin
      wr(TTC_OFS_CTRL_B, {24'h0, b});
      repeat (n) @(posedge pclk);
      wr(TTC_OFS_CTRL_B, {24'h0, b & 8'hF8});
    end
  endtask

  task automatic pin_chk(input logic [3:0] exp);
    begin
      repeat (3) @(posedge pclk);
      chk({28'h0, pins}, {28'h0, exp});
    end
  endtask

  // Ticks expected in a 1030-cycle span for prescale codes 1..5
  function automatic logic [7:0] span_ticks(input int code);
    int sh [5] = '{0, 3, 6, 8, 10};
    return 8'(1030 >> sh[code - 1]);
  endfunction

  // ==========================================================
  // Main sequence
  initial
  begin
    seed = 32'h1A40E1AF;
    presetn = 1'b0;
    ext_count_pin = 1'b0;
    port_data = 2'h0;
    port_dir = 2'h0;
    irq_ack = 3'h0;
    errors = 0;
    checks_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({28'h0, pins}, 32'h5);
    rdc(TTC_OFS_COUNT, 32'h0);
    rdc(TTC_OFS_FLAGS, 32'h0);
    bus(1'b1, 8'h1C, 32'hFF);
    chk({31'h0, e}, 32'h1);
    bus(1'b0, 8'h1C, 32'h0);
    chk({31'h0, e} ^ q, 32'h1);
    // Output state set up by force strobes while pins are inputs
    port_data <= 2'h3;
    wr(TTC_OFS_CTRL_A, 32'h40);
    pin_chk(4'h7);
    for (i = 0; i < 4; i++)
    begin
      wr(TTC_OFS_CTRL_A, {24'h0, acts[i], 6'h0});
      wr(TTC_OFS_CTRL_B, 32'h80);
      pin_chk({exps[i], 3'h7});
    end
    rdc(TTC_OFS_FLAGS, 32'h0);
    wr(TTC_OFS_CTRL_A, 32'h0);
    wr(TTC_OFS_CTRL_B, 32'h80);
    port_data <= 2'h2;
    pin_chk(4'h7);
    wr(TTC_OFS_CTRL_A, 32'h02);
    wr(TTC_OFS_CTRL_A, 32'h00);
    wr(TTC_OFS_CTRL_A, 32'h80);
    pin_chk(4'hF);
    port_dir <= 2'h1;
    port_data <= 2'h0;
    pin_chk(4'h9);
    wr(TTC_OFS_CTRL_A, 32'h30);
    wr(TTC_OFS_CTRL_B, 32'h40);
    pin_chk(4'h3);
    wr(TTC_OFS_CTRL_A, 32'h0);
    // Every prescale code, then stopped count must hold still
    for (k = 1; k < 6; k++)
    begin
      wr(TTC_OFS_COUNT, 32'h0);
      run(8'(k), 1030);
      bus(1'b0, TTC_OFS_COUNT, 32'h0);
      d = q[7:0] - span_ticks(k);
      chk(32'(d <= 8'h04 || d >= 8'hFD), 32'h1);
      g = q[7:0];
      repeat (20) @(posedge pclk);
      rdc(TTC_OFS_COUNT, {24'h0, g});
    end
    // External pin, falling then rising edges
    for (k = 6; k < 8; k++)
    begin
      wr(TTC_OFS_COUNT, 32'h0);
      wr(TTC_OFS_CTRL_B, k);
      repeat (5)
      begin
        ext_count_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        ext_count_pin <= 1'b0;
        repeat (6) @(posedge pclk);
      end
      wr(TTC_OFS_CTRL_B, 32'h0);
      rdc(TTC_OFS_COUNT, 32'h5);
    end
    // Overflow flag, mask gating and service clear
    wr(TTC_OFS_CMP_A, 32'h80);
    wr(TTC_OFS_CMP_B, 32'h80);
    wr(TTC_OFS_FLAGS, 32'h7);
    wr(TTC_OFS_COUNT, 32'hFE);
    run(8'h01, 4);
    rdc(TTC_OFS_FLAGS, 32'h1);
    repeat (3) @(posedge pclk);
    chk({29'h0, irq_req}, 32'h0);
    wr(TTC_OFS_MASK, 32'h1);
    repeat (3) @(posedge pclk);
    chk({29'h0, irq_req}, 32'h1);
    irq_ack <= 3'h1;
    @(posedge pclk);
    irq_ack <= 3'h0;
    rdc(TTC_OFS_FLAGS, 32'h0);
    chk({29'h0, irq_req}, 32'h0);
    // Count write while counting every cycle
    wr(TTC_OFS_CTRL_B, 32'h1);
    wr(TTC_OFS_COUNT, 32'h40);
    wr(TTC_OFS_CTRL_B, 32'h0);
    bus(1'b0, TTC_OFS_COUNT, 32'h0);
    d = q[7:0] - 8'h40;
    chk(32'(d >= 8'h01 && d <= 8'h04), 32'h1);
    // Random compare points: matches, then blocking after a write
    for (i = 0; i < 4; i++)
    begin
      c = 8'h08 + 8'($unsigned($random(seed)) % 200);
      pd = 2'($random(seed));
      pr = 2'($random(seed));
      port_data <= pd;
      port_dir <= pr;
      pin_chk({pd[0], ~pr[0], pd[1], ~pr[1]});
      wr(TTC_OFS_CMP_A, {24'h0, c});
      wr(TTC_OFS_CMP_B, {24'h0, c + 8'h02});
      wr(TTC_OFS_FLAGS, 32'h7);
      rdc(TTC_OFS_FLAGS, 32'h0);
      wr(TTC_OFS_COUNT, {24'h0, c - 8'h04});
      run(8'h01, 6);
      rdc(TTC_OFS_FLAGS, 32'h6);
      wr(TTC_OFS_FLAGS, 32'h0);
      rdc(TTC_OFS_FLAGS, 32'h6);
      wr(TTC_OFS_FLAGS, 32'h7);
      wr(TTC_OFS_COUNT, {24'h0, c});
      run(8'h01, 6);
      rdc(TTC_OFS_FLAGS, 32'h4);
    end
    // Fast PWM with compare top: compare B writes go to the buffer
    wr(TTC_OFS_CMP_A, 32'hF0);
    wr(TTC_OFS_CMP_B, 32'h10);
    wr(TTC_OFS_CTRL_A, 32'h03);
    wr(TTC_OFS_CTRL_B, 32'h08);
    wr(TTC_OFS_CMP_B, 32'h20);
    rdc(TTC_OFS_CMP_B, 32'h20);
    wr(TTC_OFS_FLAGS, 32'h7);
    wr(TTC_OFS_COUNT, 32'h1C);
    run(8'h09, 6);
    bus(1'b0, TTC_OFS_FLAGS, 32'h0);
    chk({31'h0, q[2]}, 32'h0);
    // Non-inverted fast PWM: a compare B match clears its output
    wr(TTC_OFS_CTRL_A, 32'hA3);
    wr(TTC_OFS_COUNT, 32'h0C);
    run(8'h09, 6);
    chk({31'h0, pins.out_b}, 32'h0);
    close_out();
  end
endmodule
